// *** rtl/lsc_pkg.sv ***
package lsc_pkg;

  // serial word layout
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam logic RW_READ = 1'b1;

  // register offsets
  localparam logic [6:0] OFF_ENABLES = 7'h01;
  localparam logic [6:0] OFF_INT_DIV = 7'h02;
  localparam logic [6:0] OFF_FRAC_DIV = 7'h03;
  localparam logic [6:0] OFF_MODULUS_DIVIDER = 7'h04;
  localparam logic [6:0] OFF_REF_MUX = 7'h21;
  localparam logic [6:0] OFF_LO_PATH = 7'h22;
  localparam logic [6:0] OFF_TRIM = 7'h31;
  localparam logic [6:0] OFF_POLARITY = 7'h32;
  localparam logic [6:0] OFF_INT_SET = 7'h49;
  localparam logic [6:0] OFF_STATUS = 7'h7f;

  // reset values
  localparam logic [15:0] RST_ENABLES = 16'h0000;
  localparam logic [15:0] RST_INT_DIV = 16'h0000;
  localparam logic [15:0] RST_FRAC_DIV = 16'h0000;
  localparam logic [15:0] RST_MODULUS_DIVIDER = 16'h0000;
  localparam logic [15:0] RST_REF_MUX = 16'h0000;
  localparam logic [15:0] RST_LO_PATH = 16'h0000;
  localparam logic [15:0] RST_TRIM = 16'h0000;
  localparam logic [15:0] RST_POLARITY = 16'h0000;
  localparam logic [15:0] RST_INT_SET = 16'h0000;

  // field positions
  localparam int ENA_DRV1X_BIT = 7;
  localparam int ENA_DRV2X_BIT = 8;
  localparam int INT_MODE_BIT = 11;
  localparam int PFD_POL_BIT = 3;
  localparam int MUX_SEL_LSB = 4;
  localparam int VCO_SEL_LSB = 0;
  localparam int DIV4_BIT = 3;
  localparam int DIV8_BIT = 4;
  localparam int DRVDIV2_BIT = 5;
  localparam int LVL_LSB = 6;
  localparam int I_POLARITY_LSB = 8;
  localparam int Q_POLARITY_LSB = 10;
  localparam int AMP_LSB = 6;
  localparam int PHASE_LSB = 0;
  localparam int INT_SET_W = 14;

  // field codes
  localparam logic [2:0] VCO_SEL_EXT = 3'h4;
  localparam logic [1:0] I_POLARITY_INVERT = 2'h2;
  localparam logic [1:0] Q_POLARITY_INVERT = 2'h1;
  localparam logic [1:0] LVL_HIGHEST = 2'h2;
  localparam logic [3:0] RATIO_2 = 4'h2;
  localparam logic [3:0] RATIO_4 = 4'h4;
  localparam logic [3:0] RATIO_8 = 4'h8;

  // band calibration length in detector cycles
  localparam int CAL_PFD_CYCLES = 94208;
  localparam int CAL_CNT_W = 17;

  typedef enum logic [2:0] {
    MUX_LOCK = 3'h0,
    MUX_CAL_BUSY = 3'h1,
    MUX_LOW = 3'h2,
    MUX_HIGH = 3'h3
  } lsc_mux_e;

  typedef struct packed {
    logic [6:0] addr;
    logic [15:0] data;
  } lsc_wr_s;

  typedef struct packed {
    logic [15:0] int_word;
    logic [15:0] frac_word;
    logic [15:0] mod_word;
  } lsc_div_s;

  typedef struct packed {
    logic pll_enable;
    logic vco_power_on;
    logic ext_lo_mode;
    logic [1:0] vco_core;
    logic integer_mode;
    logic osc_out_double;
    logic single_rate_path;
    logic [3:0] final_divide_ratio;
    logic [1:0] drive_level;
    logic i_invert;
    logic q_invert;
  } lsc_lo_s;

endpackage

// *** rtl/lsc_serial_port.sv ***
`timescale 1ns/100ps
`default_nettype none
module lsc_serial_port
  import lsc_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic sdio_in,
  input wire logic cs_n,
  input wire logic [15:0] rd_data,
  output logic [6:0] rd_addr,
  output logic sdio_out,
  output logic sdio_oe,
  output logic wr_valid,
  output lsc_wr_s wr_req
);

  typedef enum logic [2:0] {
    SP_IDLE = 3'b001,
    SP_HEAD = 3'b010,
    SP_DATA = 3'b100
  } lsc_sp_state_e;

  lsc_sp_state_e state_reg, state_next;
  logic sclk_reg;
  logic [2:0] cnt_reg, cnt_next;
  logic [7:0] head_reg, head_next;
  logic [15:0] data_reg, data_next;
  logic [4:0] dcnt_reg, dcnt_next;
  logic [15:0] shout_reg, shout_next;
  logic oe_reg, oe_next;
  logic wr_valid_reg, wr_valid_next;
  lsc_wr_s wr_req_reg, wr_req_next;
  logic rise, fall;

  // pins are synchronous to clock, so edges come from one stored sample
  assign rise = sclk & ~sclk_reg;
  assign fall = ~sclk & sclk_reg;

  // frame decode; a write lands when select is released
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    head_next = head_reg;
    data_next = data_reg;
    dcnt_next = dcnt_reg;
    shout_next = shout_reg;
    oe_next = oe_reg;
    wr_valid_next = 1'b0;
    wr_req_next = wr_req_reg;
    if (cs_n) begin
      if (state_reg == SP_DATA && head_reg[0] != RW_READ &&
          dcnt_reg != 5'h00) begin
        wr_valid_next = 1'b1;
        wr_req_next.addr = head_reg[7:1];
        wr_req_next.data = data_reg; // short frame: bits sit low
      end
      state_next = SP_IDLE;
      oe_next = 1'b0;
    end else begin
      case (state_reg)
        SP_IDLE: begin
          state_next = SP_HEAD;
          cnt_next = 3'h0;
          dcnt_next = 5'h00;
          data_next = 16'h0000;
        end
        SP_HEAD: begin
          if (rise) begin
            head_next = {head_reg[6:0], sdio_in};
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'h7) state_next = SP_DATA;
          end
        end
        SP_DATA: begin
          // extra bits keep only the 16 most recent
          if (rise) begin
            data_next = {data_reg[14:0], sdio_in};
            if (dcnt_reg != 5'h10) dcnt_next = dcnt_reg + 5'h01;
          end
          if (fall && head_reg[0] == RW_READ) begin
            if (!oe_reg) begin
              shout_next = rd_data;
              oe_next = 1'b1;
            end else begin
              shout_next = {shout_reg[14:0], 1'b0};
            end
          end
        end
        default: state_next = SP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= SP_IDLE;
      sclk_reg <= 1'b0;
      cnt_reg <= 3'h0;
      head_reg <= 8'h00;
      data_reg <= 16'h0000;
      dcnt_reg <= 5'h00;
      shout_reg <= 16'h0000;
      oe_reg <= 1'b0;
      wr_valid_reg <= 1'b0;
      wr_req_reg <= '0;
    end else begin
      state_reg <= state_next;
      sclk_reg <= sclk;
      cnt_reg <= cnt_next;
      head_reg <= head_next;
      data_reg <= data_next;
      dcnt_reg <= dcnt_next;
      shout_reg <= shout_next;
      oe_reg <= oe_next;
      wr_valid_reg <= wr_valid_next;
      wr_req_reg <= wr_req_next;
    end
  end

  assign rd_addr = head_reg[7:1];
  assign sdio_out = shout_reg[15];
  assign sdio_oe = oe_reg;
  assign wr_valid = wr_valid_reg;
  assign wr_req = wr_req_reg;

endmodule
`default_nettype wire

// *** rtl/lsc_band_cal.sv ***
`timescale 1ns/100ps
`default_nettype none
module lsc_band_cal
  import lsc_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_PFD_CYCLES
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic start,
  output logic busy,
  output logic done
);

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN = 2'b10
  } lsc_cal_state_e;

  lsc_cal_state_e state_reg, state_next;
  logic [CAL_CNT_W-1:0] cnt_reg, cnt_next;
  logic done_reg, done_next;
  logic [CAL_CNT_W-1:0] run_len_reg;

  // counts detector clocks, so duration tracks the reference rate
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    done_next = 1'b0;
    case (state_reg)
      CAL_IDLE: begin
        if (start) begin
          state_next = CAL_RUN;
          cnt_next = CAL_CNT_W'(CAL_CYCLES - 1);
        end
      end
      CAL_RUN: begin
        if (start) begin
          cnt_next = CAL_CNT_W'(CAL_CYCLES - 1);
        end else if (cnt_reg == '0) begin
          state_next = CAL_IDLE;
          done_next = 1'b1;
        end else begin
          cnt_next = cnt_reg - CAL_CNT_W'(1);
        end
      end
      default: state_next = CAL_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= CAL_IDLE;
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign busy = (state_reg == CAL_RUN);
  assign done = done_reg;

  // helper: length of the current busy run since its last start
  always_ff @(posedge clock) begin
    if (!reset_n || start) run_len_reg <= '0;
    else if (busy) run_len_reg <= run_len_reg + CAL_CNT_W'(1);
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_cal_start;
    start |=> busy && cnt_reg == CAL_CNT_W'(CAL_CYCLES - 1);
  endproperty
  a_cal_start: assert property (p_cal_start)
    else $error("calibration did not start on request");

  property p_cal_len;
    $fell(busy) |-> $past(run_len_reg) == CAL_CNT_W'(CAL_CYCLES - 1);
  endproperty
  a_cal_len: assert property (p_cal_len)
    else $error("calibration length differs from programmed count");

  property p_cal_done;
    $fell(busy) |-> done;
  endproperty
  a_cal_done: assert property (p_cal_done)
    else $error("calibration end not flagged");

  c_cal_done: cover property (done);

endmodule
`default_nettype wire

// *** rtl/lsc_lo_synth_control.sv ***
// What this block does
// - after the last divider write, a VCO band calibration runs by itself.
// - band calibration lasts 94208 detector clock cycles.
// - writing any divider register starts the calibration.
// - lock detect may drive the status pin, high while locked.
// - status pin select at bits 6:4 of 0x21, reset picks lock detect.
// - VCO select value 4 takes the LO from the external input pins.
// - with external VCO, PLL stays enabled while internal VCO is off.
// - Q polarity code 01 inverts Q, code 10 is normal.
// - I polarity code 01 is normal, code 10 inverts I.
// - LO output rate is twice or once, set by two driver bits.
// - enables bit 7 turns on the unambiguous single rate LO output.
// - drive level codes 00, 01, 10 give rising output amplitude.
// - final Final_divide_ratio divides by 2, 4 or 8.
// - linearity trim holds 7-bit amplitude and 6-bit phase fields.
// - divide bits 0,0 give 2; 0,1 give 4; 1,1 give 8.
// - integer divider bit 11 picks fractional or integer; reset fractional.
`timescale 1ns/100ps
`default_nettype none
module lsc_lo_synth_control
  import lsc_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_PFD_CYCLES
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  input wire logic cs_n,
  input wire logic loop_in_lock,
  output logic muxed_status_pin,
  output lsc_lo_s lo_ctrl,
  output lsc_div_s divider_words,
  output logic detector_polarity,
  output logic [6:0] amplitude_correction,
  output logic [5:0] phase_correction,
  output logic [13:0] internal_settings,
  output logic [6:0] block_enable_bits
);

  logic [15:0] ena_reg, ena_next;
  logic [15:0] int_reg, int_next;
  logic [15:0] frac_reg, frac_next;
  logic [15:0] mod_reg, mod_next;
  logic [15:0] refmux_reg, refmux_next;
  logic [15:0] lopath_reg, lopath_next;
  logic [15:0] trim_reg, trim_next;
  logic [15:0] pol_reg, pol_next;
  logic [15:0] intset_reg, intset_next;
  logic cal_seen_reg, cal_seen_next;
  logic pin_reg, pin_next;
  lsc_lo_s lo_reg, lo_next;

  logic wr_valid;
  lsc_wr_s wr_req;
  logic [6:0] rd_addr;
  logic [15:0] rd_data;
  logic cal_start, cal_busy, cal_done;
  logic locked;
  lsc_mux_e mux_sel;
  logic [2:0] vco_sel;

  // address match, shared by write, read and calibration trigger
  function automatic logic hit(
    input logic [6:0] a,
    input logic [6:0] off
  );
    return a == off;
  endfunction

  lsc_serial_port u_serial (
    .clock(clock),
    .reset_n(reset_n),
    .sclk(sclk),
    .sdio_in(sdio_in),
    .cs_n(cs_n),
    .rd_data(rd_data),
    .rd_addr(rd_addr),
    .sdio_out(sdio_out),
    .sdio_oe(sdio_oe),
    .wr_valid(wr_valid),
    .wr_req(wr_req)
  );

  // any divider write (re)starts band calibration, so it is last step
  assign cal_start = wr_valid && (hit(wr_req.addr, OFF_INT_DIV) ||
    hit(wr_req.addr, OFF_FRAC_DIV) ||
    hit(wr_req.addr, OFF_MODULUS_DIVIDER));

  lsc_band_cal #(
    .CAL_CYCLES(CAL_CYCLES)
  ) u_cal (
    .clock(clock),
    .reset_n(reset_n),
    .start(cal_start),
    .busy(cal_busy),
    .done(cal_done)
  );

  // register file writes
  always_comb begin
    ena_next = ena_reg;
    int_next = int_reg;
    frac_next = frac_reg;
    mod_next = mod_reg;
    refmux_next = refmux_reg;
    lopath_next = lopath_reg;
    trim_next = trim_reg;
    pol_next = pol_reg;
    intset_next = intset_reg;
    if (wr_valid) begin
      if (hit(wr_req.addr, OFF_ENABLES)) ena_next = wr_req.data;
      if (hit(wr_req.addr, OFF_INT_DIV)) int_next = wr_req.data;
      if (hit(wr_req.addr, OFF_FRAC_DIV)) frac_next = wr_req.data;
      if (hit(wr_req.addr, OFF_MODULUS_DIVIDER)) mod_next = wr_req.data;
      if (hit(wr_req.addr, OFF_REF_MUX)) refmux_next = wr_req.data;
      if (hit(wr_req.addr, OFF_LO_PATH)) lopath_next = wr_req.data;
      if (hit(wr_req.addr, OFF_TRIM)) trim_next = wr_req.data;
      if (hit(wr_req.addr, OFF_POLARITY)) pol_next = wr_req.data;
      if (hit(wr_req.addr, OFF_INT_SET)) intset_next = wr_req.data;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ena_reg <= RST_ENABLES;
      int_reg <= RST_INT_DIV;
      frac_reg <= RST_FRAC_DIV;
      mod_reg <= RST_MODULUS_DIVIDER;
      refmux_reg <= RST_REF_MUX;
      lopath_reg <= RST_LO_PATH;
      trim_reg <= RST_TRIM;
      pol_reg <= RST_POLARITY;
      intset_reg <= RST_INT_SET;
    end else begin
      ena_reg <= ena_next;
      int_reg <= int_next;
      frac_reg <= frac_next;
      mod_reg <= mod_next;
      refmux_reg <= refmux_next;
      lopath_reg <= lopath_next;
      trim_reg <= trim_next;
      pol_reg <= pol_next;
      intset_reg <= intset_next;
    end
  end

  // readback; unmapped addresses read zero
  always_comb begin
    rd_data = 16'h0000;
    if (hit(rd_addr, OFF_ENABLES)) rd_data = ena_reg;
    if (hit(rd_addr, OFF_INT_DIV)) rd_data = int_reg;
    if (hit(rd_addr, OFF_FRAC_DIV)) rd_data = frac_reg;
    if (hit(rd_addr, OFF_MODULUS_DIVIDER)) rd_data = mod_reg;
    if (hit(rd_addr, OFF_REF_MUX)) rd_data = refmux_reg;
    if (hit(rd_addr, OFF_LO_PATH)) rd_data = lopath_reg;
    if (hit(rd_addr, OFF_TRIM)) rd_data = trim_reg;
    if (hit(rd_addr, OFF_POLARITY)) rd_data = pol_reg;
    if (hit(rd_addr, OFF_INT_SET)) rd_data = intset_reg;
    if (hit(rd_addr, OFF_STATUS)) rd_data = {14'h0000, locked, cal_busy};
  end

  assign mux_sel = lsc_mux_e'(refmux_reg[MUX_SEL_LSB +: 3]);
  assign vco_sel = lopath_reg[VCO_SEL_LSB +: 3];

  // lock is only trusted once a band has been picked and no cal runs
  assign locked = cal_seen_reg && !cal_busy && loop_in_lock;

  // status pin and lock bookkeeping
  always_comb begin
    cal_seen_next = cal_seen_reg | cal_done;
    case (mux_sel)
      MUX_LOCK: pin_next = locked;
      MUX_CAL_BUSY: pin_next = cal_busy;
      MUX_HIGH: pin_next = 1'b1;
      default: pin_next = 1'b0;
    endcase
  end

  // decoded LO path controls, registered so the pins never glitch
  always_comb begin
    lo_next.pll_enable = 1'b1;
    lo_next.ext_lo_mode = vco_sel[2];
    lo_next.vco_power_on = !vco_sel[2];
    lo_next.vco_core = vco_sel[1:0];
    lo_next.integer_mode = int_reg[INT_MODE_BIT];
    lo_next.osc_out_double = ena_reg[ENA_DRV2X_BIT] &&
      !lopath_reg[DRVDIV2_BIT];
    lo_next.single_rate_path = ena_reg[ENA_DRV1X_BIT];
    case ({lopath_reg[DIV8_BIT], lopath_reg[DIV4_BIT]})
      2'b00: lo_next.final_divide_ratio = RATIO_2;
      2'b01: lo_next.final_divide_ratio = RATIO_4;
      default: lo_next.final_divide_ratio = RATIO_8;
    endcase
    // unlisted code 11 is held at the highest level
    if (lopath_reg[LVL_LSB +: 2] > LVL_HIGHEST) begin
      lo_next.drive_level = LVL_HIGHEST;
    end else begin
      lo_next.drive_level = lopath_reg[LVL_LSB +: 2];
    end
    lo_next.i_invert = pol_reg[I_POLARITY_LSB +: 2] == I_POLARITY_INVERT;
    lo_next.q_invert = pol_reg[Q_POLARITY_LSB +: 2] == Q_POLARITY_INVERT;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cal_seen_reg <= 1'b0;
      pin_reg <= 1'b0;
      lo_reg <= '0;
    end else begin
      cal_seen_reg <= cal_seen_next;
      pin_reg <= pin_next;
      lo_reg <= lo_next;
    end
  end

  assign muxed_status_pin = pin_reg;
  assign lo_ctrl = lo_reg;
  assign divider_words = '{int_word: int_reg, frac_word: frac_reg,
    mod_word: mod_reg};
  assign detector_polarity = refmux_reg[PFD_POL_BIT];
  assign amplitude_correction = trim_reg[AMP_LSB +: 7];
  assign phase_correction = trim_reg[PHASE_LSB +: 6];
  assign internal_settings = intset_reg[INT_SET_W-1:0];
  assign block_enable_bits = ena_reg[6:0];

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_div_write_cal;
    wr_valid && hit(wr_req.addr, OFF_MODULUS_DIVIDER) |=> cal_busy;
  endproperty
  a_div_write_cal: assert property (p_div_write_cal)
    else $error("divider write did not start calibration");

  property p_lock_low_cal;
    cal_busy && mux_sel == MUX_LOCK |=> !muxed_status_pin;
  endproperty
  a_lock_low_cal: assert property (p_lock_low_cal)
    else $error("lock shown during calibration");

  property p_lock_high;
    mux_sel == MUX_LOCK && locked |=> muxed_status_pin;
  endproperty
  a_lock_high: assert property (p_lock_high)
    else $error("lock not shown on status pin");

  property p_ext_mode;
    vco_sel == VCO_SEL_EXT |=>
      lo_ctrl.ext_lo_mode && !lo_ctrl.vco_power_on && lo_ctrl.pll_enable;
  endproperty
  a_ext_mode: assert property (p_ext_mode)
    else $error("external LO select not applied");

  property p_ratio;
    lopath_reg[DIV8_BIT +: 1] == 1'b0 && lopath_reg[DIV4_BIT]
      |=> lo_ctrl.final_divide_ratio == RATIO_4;
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("divide by four not selected");

  property p_q_pol;
    pol_reg[Q_POLARITY_LSB +: 2] == 2'h2 |=> !lo_ctrl.q_invert;
  endproperty
  a_q_pol: assert property (p_q_pol)
    else $error("Q polarity code 10 inverted");

  property p_i_pol;
    pol_reg[I_POLARITY_LSB +: 2] == 2'h2 |=> lo_ctrl.i_invert;
  endproperty
  a_i_pol: assert property (p_i_pol)
    else $error("I polarity code 10 not inverted");

  property p_drv2x;
    ena_reg[ENA_DRV2X_BIT] && !lopath_reg[DRVDIV2_BIT]
      |=> lo_ctrl.osc_out_double;
  endproperty
  a_drv2x: assert property (p_drv2x)
    else $error("double rate output not selected");

  property p_mux_reset;
    $rose(reset_n) |-> mux_sel == MUX_LOCK;
  endproperty
  a_mux_reset: assert property (p_mux_reset)
    else $error("status pin not on lock detect after reset");

  c_locked: cover property (cal_done ##[1:20] muxed_status_pin);
  c_restart: cover property (cal_busy && cal_start);
  c_ext: cover property (lo_ctrl.ext_lo_mode);

endmodule
`default_nettype wire

// *** verif/lsc_lo_synth_control_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module lsc_lo_synth_control_bench
  import lsc_pkg::*;
;
  // short calibration keeps the run brief, but stays longer than one frame
  localparam int CAL = 200;
  localparam int LIMIT = 30000;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic sclk = 1'b0;
  logic sdio_in = 1'b0;
  logic cs_n = 1'b1;
  logic loop_in_lock = 1'b1;
  logic sdio_out, sdio_oe, muxed_status_pin, detector_polarity, pin_d;
  lsc_lo_s lo_ctrl;
  lsc_div_s divider_words;
  logic [6:0] amplitude_correction, block_enable_bits;
  logic [5:0] phase_correction;
  logic [13:0] internal_settings;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int t_cs, t_rise, t_fall, t1, t2, n;
  logic [15:0] exp_q[$];
  logic [15:0] sh;
  logic [6:0] offs[9] = '{OFF_ENABLES, OFF_INT_DIV, OFF_FRAC_DIV, OFF_MODULUS_DIVIDER,
    OFF_REF_MUX, OFF_LO_PATH, OFF_TRIM, OFF_POLARITY, OFF_INT_SET};
  logic [15:0] vals[9];
  logic [15:0] lp, en, pol, iv;
  lsc_lo_s e;

  lsc_lo_synth_control #(.CAL_CYCLES(CAL)) u_dut (
    .clock(clock), .reset_n(reset_n), .sclk(sclk), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .cs_n(cs_n),
    .loop_in_lock(loop_in_lock), .muxed_status_pin(muxed_status_pin),
    .lo_ctrl(lo_ctrl), .divider_words(divider_words),
    .detector_polarity(detector_polarity),
    .amplitude_correction(amplitude_correction),
    .phase_correction(phase_correction),
    .internal_settings(internal_settings),
    .block_enable_bits(block_enable_bits)
  );

  always #10 clock = ~clock;

  // cycle count, pin edge times and the hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    pin_d <= muxed_status_pin;
    if (muxed_status_pin === 1'b1 && pin_d === 1'b0) t_rise <= cyc;
    if (muxed_status_pin === 1'b0 && pin_d === 1'b1) t_fall <= cyc;
    if (cyc == LIMIT) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic chk(string what, logic [15:0] ex, logic [15:0] seen);
    total_checks++;
    if (seen !== ex) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, ex, seen);
    end
  endtask

  task automatic wrap_up();
    // a read whose data never came out leaves its note behind
    chk("pending reads", 16'h0000, 16'(exp_q.size()));
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wait3();
    repeat (3) @(posedge clock);
    #2;
  endtask

  // one frame; sclk phases of three clocks respect the sampling limit
  task automatic xfer(logic [6:0] a, logic rw, logic [15:0] d);
    logic [23:0] w;
    w = {a, rw, d};
    cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sclk = 1'b0;
      sdio_in = w[i];
      wait3();
      sclk = 1'b1;
      wait3();
    end
    sclk = 1'b0;
    wait3();
    cs_n = 1'b1;
    t_cs = cyc;
    wait3();
  endtask

  task automatic wr(logic [6:0] a, logic [15:0] d);
    xfer(a, 1'b0, d);
  endtask

  task automatic rd(logic [6:0] a, logic [15:0] ex);
    exp_q.push_back(ex);
    xfer(a, RW_READ, 16'h0000);
  endtask

  // read monitor: collects sixteen driven bits, then takes the oldest note
  initial begin
    n = 0;
    forever begin
      @(posedge sclk);
      if (sdio_oe === 1'b1) begin
        sh = {sh[14:0], sdio_out};
        n++;
        if (n == 16) begin
          n = 0;
          if (exp_q.size() == 0) chk("read note", 16'h0000, 16'h0001);
          else chk("read data", exp_q.pop_front(), sh);
        end
      end
    end
  end

  initial begin
    void'($urandom(48453));
    repeat (8) @(posedge clock);
    #2;
    reset_n = 1'b1;
    wait3();
    // locked loop, but no calibration has finished yet
    chk("pin after reset", 16'h0000, {15'h0, muxed_status_pin});
    chk("ratio", 16'(RATIO_2), 16'(lo_ctrl.final_divide_ratio));
    chk("pll enable", 16'h0001, {15'h0, lo_ctrl.pll_enable});
    foreach (offs[k]) rd(offs[k], 16'h0000);
    rd(7'h10, 16'h0000);
    // every register written and read back; random content except a fixed settings value and forced ref mux bits 6:3
    foreach (offs[k]) begin
      vals[k] = 16'($urandom());
      if (offs[k] == OFF_INT_SET) vals[k] = 16'h14b4;
      if (offs[k] == OFF_REF_MUX) begin
        vals[k] = (vals[k] & 16'hff8f) | 16'h0008;
      end
      wr(offs[k], vals[k]);
      rd(offs[k], vals[k]);
    end
    chk("divider int", vals[1], divider_words.int_word);
    chk("divider frac", vals[2], divider_words.frac_word);
    chk("divider mod", vals[3], divider_words.mod_word);
    chk("polarity", 16'h0001, {15'h0, detector_polarity});
    chk("amplitude", 16'(vals[6][12:6]), 16'(amplitude_correction));
    chk("phase", {10'h0, vals[6][5:0]}, {10'h0, phase_correction});
    chk("settings", 16'h14b4, {2'h0, internal_settings});
    // lo path codes, one table row per pass
    for (int i = 0; i < 8; i++) begin
      lp = {8'($urandom()), i[1:0], i[0], i[1:0], i[2:0]};
      en = {7'($urandom()), i[1:0], 7'($urandom())};
      pol = {4'($urandom()), i[1:0], i[2:1], 8'($urandom())};
      iv = {4'($urandom()), i[0], 11'($urandom())};
      wr(OFF_LO_PATH, lp);
      wr(OFF_ENABLES, en);
      wr(OFF_POLARITY, pol);
      wr(OFF_INT_DIV, iv);
      e.pll_enable = 1'b1;
      e.vco_power_on = ~lp[2];
      e.ext_lo_mode = lp[2];
      e.vco_core = lp[1:0];
      e.integer_mode = iv[INT_MODE_BIT];
      e.osc_out_double = en[ENA_DRV2X_BIT] & ~lp[DRVDIV2_BIT];
      e.single_rate_path = en[ENA_DRV1X_BIT];
      e.final_divide_ratio = lp[4:3] == 2'b00 ? RATIO_2 :
        lp[4:3] == 2'b01 ? RATIO_4 : RATIO_8;
      e.drive_level = lp[7:6] == 2'b11 ? LVL_HIGHEST : lp[7:6];
      e.i_invert = pol[9:8] == I_POLARITY_INVERT;
      e.q_invert = pol[11:10] == Q_POLARITY_INVERT;
      chk("lo", e, lo_ctrl);
      chk("enables", {9'h0, en[6:0]}, {9'h0, block_enable_bits});
    end
    // calibration length seen on the busy selection of the pin
    wr(OFF_REF_MUX, 16'h0018);
    repeat (CAL + 10) @(posedge clock);
    #2;
    wr(OFF_INT_DIV, 16'h0000);
    t1 = t_cs;
    repeat (CAL + 10) @(posedge clock);
    #2;
    chk("cal width", 16'(CAL), 16'(t_fall - t_rise));
    // pin follows busy one clock late: select seen high, write, then busy
    chk("cal start", 16'h0003, 16'(t_rise - t1));
    // a second divider write in mid calibration restarts the full count
    wr(OFF_FRAC_DIV, 16'($urandom()));
    t1 = t_cs;
    wr(OFF_MODULUS_DIVIDER, 16'($urandom()));
    t2 = t_cs;
    repeat (CAL + 10) @(posedge clock);
    #2;
    chk("cal restart", 16'(t2 - t1 + CAL), 16'(t_fall - t_rise));
    // lock detect selection: low while calibrating, then follows the loop
    wr(OFF_REF_MUX, 16'h0008);
    wr(OFF_INT_DIV, 16'h0000);
    chk("pin in cal", 16'h0000, {15'h0, muxed_status_pin});
    repeat (CAL) @(posedge clock);
    #2;
    chk("pin locked", 16'h0001, {15'h0, muxed_status_pin});
    rd(OFF_STATUS, 16'h0002);
    loop_in_lock = 1'b0;
    wait3();
    chk("pin unlocked", 16'h0000, {15'h0, muxed_status_pin});
    // fixed low and high selections; lock raised so a bad decode shows
    loop_in_lock = 1'b1;
    wr(OFF_REF_MUX, 16'h0028);
    chk("pin sel low", 16'h0000, {15'h0, muxed_status_pin});
    wr(OFF_REF_MUX, 16'h0038);
    chk("pin sel high", 16'h0001, {15'h0, muxed_status_pin});
    wr(OFF_REF_MUX, 16'h0048);
    chk("pin sel other", 16'h0000, {15'h0, muxed_status_pin});
    repeat (5) @(posedge clock);
    wrap_up();
  end
endmodule
`default_nettype wire
